//--- shared/hbs_pkg.sv
/*
 Shared constants and types of the hub boot mode sequencer.
 Assumes a single 40 MHz clock domain.
*/
package hbs_pkg;
    typedef enum logic [3:0] {
        st_standby,
        hardware_init_stage,
        charger_init_stage,
        reference_wait_stage,
        firmware_init_stage,
        st_bus_probe,
        st_host_cfg,
        st_configured,
        st_ext_boot,
        st_defaults
    } hbs_stage_e;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic io0_o;
        logic io0_oe;
    } hbs_spi_s;

    localparam int CLK_MHZ = 40;
    localparam int CORE_RST_NS = 500;
    localparam int CORE_RST_CYC = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_GAP_NS = 1000;
    localparam int REF_GAP_CYC = (REF_GAP_NS * CLK_MHZ) / 1000;
    localparam int PROBE_NS = 20000;
    localparam int PROBE_CYC = (PROBE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [31:0] FLASH_SIG = 32'h32444655;
    localparam logic [23:0] SIG_ADDR = 24'h00fffa;
    localparam logic [15:0] BOOT_ADDR = 16'h0000;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_DREAD = 8'h3b;
    localparam logic [6:0] ADDR_CLKS = 7'h20;
    localparam logic [6:0] DUMMY_CLKS = 7'h08;
    localparam logic [6:0] SINGLE_TOTAL = 7'h40;
    localparam logic [6:0] DUAL_TOTAL = 7'h38;
    localparam logic [1:0] HALF_FAST = 2'h1;
    localparam logic [1:0] HALF_SLOW = 2'h2;
    localparam logic [1:0] RPT_IRQ = 2'h1;
    localparam logic [1:0] RPT_CHG = 2'h2;
    localparam int SYNC_W = 7;
endpackage

//--- verilog/hbs_sequencer.sv
/*
 Hub operating-mode and boot-stage sequencer with boot flash probe.
 Assumes one 40 MHz clock; pins are synchronised here; the flash data
 pins answer our own serial clock and are sampled directly.
*/
// Notes on behaviour
// RULE1: Reset pin low standby, high hub mode
// RULE2: Standby: ports hi-z, regulators, PLL off
// RULE3: Standby keeps no configuration state
// RULE4: Reset release enters hardware init, core reset
// RULE5: Hardware init loads defaults, captures straps
// RULE6: No SMBus traffic during hardware init
// RULE7: No reference goes charger init, else firmware
// RULE8: Charger init runs ring oscillator, wakes processor
// RULE9: Ring oscillator off after charging registers load
// RULE10: Reference wait: detect on ring oscillator
// RULE11: PLL lock aborts early detection, no results
// RULE12: Detection result to irq, outputs, or neither
// RULE13: Wait for reference and lock, then firmware
// RULE14: Flash signature match boots external at zero
// RULE15: No signature: run from internal ROM
// RULE16: Flash clock rate set by speed strap
// RULE17: Single and dual bit flash reads supported
// RULE18: Flash clock modes 0 and 3 supported
// RULE19: Weak pull-downs probe for bus host
// RULE20: Reset pin switches 3.3V regulator
// RULE21: Host ends configuration by dedicated write
// RULE22: Nothing found: run internal defaults, straps
// RULE23: Current stage shown on status output
// RULE24: Reset pin low returns to standby anytime
`timescale 1ns/100ps
`default_nettype none
module hbs_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_reset_pin_n,
    input wire logic reference_clock_in,
    input wire logic pll_locked_in,
    input wire logic core_reg_ok_in,
    input wire logic flash_speed_strap,
    input wire logic spi_dual_cfg,
    input wire logic spi_mode3_cfg,
    input wire logic charger_det_en,
    input wire logic [1:0] report_sel,
    input wire logic cpu_bc_done,
    input wire logic bcd_done,
    input wire logic [1:0] bcd_result,
    input wire logic host_cfg_done,
    input wire logic spi_io0_in,
    input wire logic spi_io1_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output hbs_pkg::hbs_stage_e stage,
    output logic ports_hiz,
    output logic reg33_en,
    output logic reg12_en,
    output logic pll_en,
    output logic core_reset,
    output logic load_defaults,
    output logic speed_fast,
    output logic smbus_accept,
    output logic ring_oscillator_en,
    output logic cpu_wake,
    output logic bcd_start,
    output logic bcd_abort,
    output logic irq_n,
    output logic [1:0] charger_detect_out,
    output hbs_pkg::hbs_spi_s spi,
    output logic scl_pd_en,
    output logic sda_pd_en,
    output logic ext_rom_en,
    output logic [15:0] boot_vector,
    output logic int_defaults
);
    // Pin synchronisers: reset, reference, lock, regulator, strap, scl, sda
    logic [hbs_pkg::SYNC_W-1:0] s1_r, s2_r;
    logic ref_d_r;
    logic [15:0] ref_gap_r, ref_gap_nxt;
    logic rst_ok, ref_ok, pll_ok, core_ok, strap_s, scl_s, sda_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            ref_d_r <= 1'b0;
            ref_gap_r <= 16'h0000;
        end else begin
            s1_r <= {sda_in, scl_in, flash_speed_strap, core_reg_ok_in, pll_locked_in, reference_clock_in,
                     chip_reset_pin_n};
            s2_r <= s1_r;
            ref_d_r <= s2_r[1];
            ref_gap_r <= ref_gap_nxt;
        end
    end

    assign {sda_s, scl_s, strap_s, core_ok, pll_ok} = s2_r[6:2];
    assign rst_ok = s2_r[0];
    assign ref_ok = (ref_gap_r != 16'h0000);

    // Reference counts as present while edges keep arriving
    always_comb begin
        ref_gap_nxt = ref_gap_r;
        if (s2_r[1] != ref_d_r) begin
            ref_gap_nxt = 16'(hbs_pkg::REF_GAP_CYC);
        end else if (ref_gap_r != 16'h0000) begin
            ref_gap_nxt = ref_gap_r - 16'h0001;
        end
    end

    // Stage machine
    hbs_pkg::hbs_stage_e stage_r, stage_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic bcd_run_r, bcd_run_nxt, bcd_fin_r, bcd_fin_nxt;
    logic irq_n_r, irq_n_nxt, ext_r, ext_nxt, fast_r, fast_nxt;
    logic [1:0] chg_r, chg_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic load_r, load_nxt, start_r, start_nxt, abort_r, abort_nxt;
    logic spi_go, spi_done, sig_match;

    always_comb begin
        stage_nxt = stage_r;
        cnt_nxt = cnt_r;
        bcd_run_nxt = bcd_run_r;
        bcd_fin_nxt = bcd_fin_r;
        irq_n_nxt = irq_n_r;
        chg_nxt = chg_r;
        ext_nxt = ext_r;
        vec_nxt = vec_r;
        fast_nxt = fast_r;
        load_nxt = 1'b0;
        start_nxt = 1'b0;
        abort_nxt = 1'b0;
        spi_go = 1'b0;
        if (!rst_ok) begin
            // Every stage falls back and forgets its settings
            stage_nxt = hbs_pkg::st_standby; // RULE24
            bcd_run_nxt = 1'b0; // RULE3
            bcd_fin_nxt = 1'b0;
            irq_n_nxt = 1'b1;
            chg_nxt = 2'h0;
            ext_nxt = 1'b0;
            vec_nxt = 16'h0000;
            fast_nxt = 1'b0;
        end else begin
            unique case (stage_r)
                hbs_pkg::st_standby: begin
                    stage_nxt = hbs_pkg::hardware_init_stage; // RULE4
                    cnt_nxt = 16'(hbs_pkg::CORE_RST_CYC);
                end
                hbs_pkg::hardware_init_stage: begin
                    if (core_ok && cnt_r != 16'h0000) begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end else if (core_ok) begin
                        load_nxt = 1'b1; // RULE5
                        fast_nxt = strap_s;
                        if (!ref_ok) begin
                            stage_nxt = hbs_pkg::charger_init_stage; // RULE7
                        end else if (pll_ok) begin
                            stage_nxt = hbs_pkg::firmware_init_stage; // RULE13
                            spi_go = 1'b1;
                        end else begin
                            stage_nxt = hbs_pkg::reference_wait_stage;
                        end
                    end
                end
                hbs_pkg::charger_init_stage: begin
                    if (cpu_bc_done) begin
                        stage_nxt = hbs_pkg::reference_wait_stage; // RULE9
                    end
                end
                hbs_pkg::reference_wait_stage: begin
                    if (ref_ok && pll_ok) begin
                        stage_nxt = hbs_pkg::firmware_init_stage; // RULE13
                        spi_go = 1'b1;
                        if (bcd_run_r) begin
                            abort_nxt = 1'b1; // RULE11
                            bcd_run_nxt = 1'b0;
                        end
                    end else if (bcd_run_r && bcd_done) begin
                        bcd_run_nxt = 1'b0;
                        bcd_fin_nxt = 1'b1;
                        if (report_sel == hbs_pkg::RPT_IRQ) begin
                            irq_n_nxt = 1'b0; // RULE12
                        end else if (report_sel == hbs_pkg::RPT_CHG) begin
                            chg_nxt = bcd_result; // RULE12
                        end
                    end else if (!ref_ok && charger_det_en && !bcd_run_r && !bcd_fin_r) begin
                        start_nxt = 1'b1; // RULE10
                        bcd_run_nxt = 1'b1;
                    end
                end
                hbs_pkg::firmware_init_stage: begin
                    if (spi_done && sig_match) begin
                        stage_nxt = hbs_pkg::st_ext_boot; // RULE14
                        ext_nxt = 1'b1;
                        vec_nxt = hbs_pkg::BOOT_ADDR;
                    end else if (spi_done) begin
                        stage_nxt = hbs_pkg::st_bus_probe; // RULE15
                        cnt_nxt = 16'(hbs_pkg::PROBE_CYC);
                    end
                end
                hbs_pkg::st_bus_probe: begin
                    if (cnt_r != 16'h0000) begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end else if (scl_s && sda_s) begin
                        stage_nxt = hbs_pkg::st_host_cfg; // RULE19
                    end else begin
                        stage_nxt = hbs_pkg::st_defaults; // RULE22
                    end
                end
                hbs_pkg::st_host_cfg: begin
                    if (host_cfg_done) begin
                        stage_nxt = hbs_pkg::st_configured; // RULE21
                    end
                end
                hbs_pkg::st_configured, hbs_pkg::st_ext_boot, hbs_pkg::st_defaults: begin
                    stage_nxt = stage_r;
                end
                default: begin
                    stage_nxt = hbs_pkg::st_standby;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= hbs_pkg::st_standby;
            cnt_r <= 16'h0000;
            bcd_run_r <= 1'b0;
            bcd_fin_r <= 1'b0;
            irq_n_r <= 1'b1;
            chg_r <= 2'h0;
            ext_r <= 1'b0;
            vec_r <= 16'h0000;
            fast_r <= 1'b0;
            load_r <= 1'b0;
            start_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            stage_r <= stage_nxt;
            cnt_r <= cnt_nxt;
            bcd_run_r <= bcd_run_nxt;
            bcd_fin_r <= bcd_fin_nxt;
            irq_n_r <= irq_n_nxt;
            chg_r <= chg_nxt;
            ext_r <= ext_nxt;
            vec_r <= vec_nxt;
            fast_r <= fast_nxt;
            load_r <= load_nxt;
            start_r <= start_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign stage = stage_r; // RULE23
    assign ports_hiz = (stage_r == hbs_pkg::st_standby); // RULE2
    assign reg33_en = (stage_r != hbs_pkg::st_standby); // RULE20
    assign reg12_en = (stage_r != hbs_pkg::st_standby); // RULE1
    assign pll_en = (stage_r != hbs_pkg::st_standby);
    assign core_reset = (stage_r == hbs_pkg::hardware_init_stage) && (cnt_r != 16'h0000); // RULE4
    assign smbus_accept = (stage_r == hbs_pkg::st_host_cfg) || (stage_r == hbs_pkg::st_configured)
                          || (stage_r == hbs_pkg::st_defaults); // RULE6
    assign ring_oscillator_en = (stage_r == hbs_pkg::charger_init_stage)
                                || (stage_r == hbs_pkg::reference_wait_stage && bcd_run_r); // RULE8
    assign cpu_wake = (stage_r == hbs_pkg::charger_init_stage);
    assign scl_pd_en = (stage_r == hbs_pkg::st_bus_probe);
    assign sda_pd_en = (stage_r == hbs_pkg::st_bus_probe);
    assign int_defaults = (stage_r == hbs_pkg::st_defaults);
    assign load_defaults = load_r;
    assign speed_fast = fast_r;
    assign bcd_start = start_r;
    assign bcd_abort = abort_r;
    assign irq_n = irq_n_r;
    assign charger_detect_out = chg_r;
    assign ext_rom_en = ext_r;
    assign boot_vector = vec_r;

    // Boot flash signature read
    logic busy_r, busy_nxt, sclk_r, sclk_nxt, csn_r, csn_nxt, rose_r, rose_nxt;
    logic fin_r, fin_nxt, dual_r, dual_nxt, done_r, done_nxt;
    logic [31:0] sh_r, sh_nxt, in_r, in_nxt;
    logic [6:0] rise_r, rise_nxt;
    logic [1:0] div_r, div_nxt, half;
    logic [6:0] total, dstart;

    assign half = fast_r ? hbs_pkg::HALF_FAST : hbs_pkg::HALF_SLOW; // RULE16
    assign total = dual_r ? hbs_pkg::DUAL_TOTAL : hbs_pkg::SINGLE_TOTAL;
    assign dstart = dual_r ? (hbs_pkg::ADDR_CLKS + hbs_pkg::DUMMY_CLKS) : hbs_pkg::ADDR_CLKS;

    always_comb begin
        busy_nxt = busy_r;
        sclk_nxt = sclk_r;
        csn_nxt = csn_r;
        rose_nxt = rose_r;
        fin_nxt = fin_r;
        dual_nxt = dual_r;
        sh_nxt = sh_r;
        in_nxt = in_r;
        rise_nxt = rise_r;
        div_nxt = div_r;
        done_nxt = 1'b0;
        if (!rst_ok) begin
            busy_nxt = 1'b0;
            csn_nxt = 1'b1;
            // Clock parks at its mode level so select falls with no clock edge; it can rise with one
            sclk_nxt = spi_mode3_cfg; // RULE18
        end else if (spi_go) begin
            busy_nxt = 1'b1;
            csn_nxt = 1'b0;
            sclk_nxt = spi_mode3_cfg; // RULE18
            dual_nxt = spi_dual_cfg; // RULE17
            sh_nxt = {(spi_dual_cfg ? hbs_pkg::CMD_DREAD : hbs_pkg::CMD_READ), hbs_pkg::SIG_ADDR};
            rise_nxt = 7'h00;
            rose_nxt = 1'b0;
            fin_nxt = 1'b0;
            div_nxt = 2'h0;
        end else if (busy_r) begin
            div_nxt = div_r + 2'h1;
            if (div_r + 2'h1 == half) begin
                div_nxt = 2'h0;
                if (!sclk_r) begin
                    // Rising edge: flash data is sampled here
                    sclk_nxt = 1'b1;
                    rose_nxt = 1'b1;
                    rise_nxt = rise_r + 7'h01;
                    if (rise_r >= dstart) begin
                        in_nxt = dual_r ? {in_r[29:0], spi_io1_in, spi_io0_in} : {in_r[30:0], spi_io1_in};
                    end
                    fin_nxt = (rise_r + 7'h01 == total);
                end else if (fin_r) begin
                    busy_nxt = 1'b0;
                    csn_nxt = 1'b1;
                    sclk_nxt = spi_mode3_cfg;
                    done_nxt = 1'b1;
                end else begin
                    sclk_nxt = 1'b0;
                    if (rose_r) begin
                        sh_nxt = {sh_r[30:0], 1'b0};
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            sclk_r <= 1'b0;
            csn_r <= 1'b1;
            rose_r <= 1'b0;
            fin_r <= 1'b0;
            dual_r <= 1'b0;
            sh_r <= 32'h00000000;
            in_r <= 32'h00000000;
            rise_r <= 7'h00;
            div_r <= 2'h0;
            done_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            sclk_r <= sclk_nxt;
            csn_r <= csn_nxt;
            rose_r <= rose_nxt;
            fin_r <= fin_nxt;
            dual_r <= dual_nxt;
            sh_r <= sh_nxt;
            in_r <= in_nxt;
            rise_r <= rise_nxt;
            div_r <= div_nxt;
            done_r <= done_nxt;
        end
    end

    assign spi_done = done_r;
    assign sig_match = (in_r == hbs_pkg::FLASH_SIG); // RULE14
    assign spi = {sclk_r, csn_r, sh_r[31], busy_r && (!dual_r || rise_r < hbs_pkg::ADDR_CLKS)};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_probe_end;
        stage_r == hbs_pkg::st_bus_probe && cnt_r == 16'h0000 && rst_ok;
    endsequence

    property p_standby_off;
        ports_hiz |-> !reg12_en && !reg33_en && !pll_en && !spi.io0_oe && !ring_oscillator_en;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("standby left something on"); // RULE2

    property p_reset_back;
        !rst_ok |=> stage == hbs_pkg::st_standby && !ext_rom_en && irq_n;
    endproperty
    a_reset_back: assert property (p_reset_back) else $error("reset did not return to standby"); // RULE24

    property p_enter_hw;
        stage == hbs_pkg::st_standby && rst_ok |=> stage == hbs_pkg::hardware_init_stage && core_reset;
    endproperty
    a_enter_hw: assert property (p_enter_hw) else $error("release did not start hardware init"); // RULE4

    property p_no_smbus_hw;
        stage == hbs_pkg::hardware_init_stage |-> !smbus_accept;
    endproperty
    a_no_smbus_hw: assert property (p_no_smbus_hw) else $error("smbus accepted in hardware init"); // RULE6

    property p_no_ref;
        stage == hbs_pkg::hardware_init_stage && !core_reset && core_ok && !ref_ok && rst_ok
            |=> stage == hbs_pkg::charger_init_stage && load_defaults && ring_oscillator_en;
    endproperty
    a_no_ref: assert property (p_no_ref) else $error("no reference did not go to charger init"); // RULE7

    property p_osc_off;
        stage == hbs_pkg::charger_init_stage && cpu_bc_done && rst_ok |=> !ring_oscillator_en;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("ring oscillator left running"); // RULE9

    property p_abort;
        stage == hbs_pkg::reference_wait_stage && bcd_run_r && ref_ok && pll_ok && rst_ok
            |=> bcd_abort && stage == hbs_pkg::firmware_init_stage && $stable(charger_detect_out) && irq_n;
    endproperty
    a_abort: assert property (p_abort) else $error("lock did not abort detection"); // RULE11

    property p_ext_boot;
        stage == hbs_pkg::firmware_init_stage && spi_done && sig_match && rst_ok
            |=> ext_rom_en && boot_vector == hbs_pkg::BOOT_ADDR && stage == hbs_pkg::st_ext_boot;
    endproperty
    a_ext_boot: assert property (p_ext_boot) else $error("signature match did not boot external"); // RULE14

    property p_probe;
        s_probe_end ##0 (scl_s && sda_s) |-> scl_pd_en ##1 stage == hbs_pkg::st_host_cfg;
    endproperty
    a_probe: assert property (p_probe) else $error("bus host not detected"); // RULE19

    property p_fast_clk;
        busy_r && fast_r && $rose(sclk_r) |=> $fell(sclk_r) || !busy_r;
    endproperty
    a_fast_clk: assert property (p_fast_clk) else $error("fast flash clock half period wrong"); // RULE16
endmodule
`default_nettype wire

//--- bench/hbs_flash_model.sv
/*
 Boot flash stand-in: records the 32 command and address bits on mosi, then
 shifts out the word on sig, MSB first, on io1 (single) or as bit pairs on
 io1 and io0 after 8 dummy clocks (dual). It updates on the falling clock.
 Assumes the clock modes 0 and 3 of the sequencer; outside a read the data
 pins show the inverse of their last values.
*/
`timescale 1ns/100ps
`default_nettype none
module hbs_flash_model (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic dual,
    input wire logic [31:0] sig,
    output logic io0,
    output logic io1,
    output logic [31:0] cmd
);
    int rises = 0;
    initial io1 = 1'b0;
    initial io0 = 1'b1;
    // Rising clocks counted only while selected
    always @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rises <= 0;
        end else begin
            rises <= rises + 1;
            if (rises < 32)
                cmd <= {cmd[30:0], mosi};
        end
    end
    // Data bits ready before the rise that samples them
    always @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            io1 <= ~io1;
            io0 <= ~io0;
        end else if (!dual && rises >= 32 && rises <= 63) begin
            io1 <= sig[63 - rises];
        end else if (dual && rises >= 40 && rises <= 55) begin
            io1 <= sig[111 - 2 * rises];
            io0 <= sig[110 - 2 * rises];
        end
    end
endmodule
`default_nettype wire

//--- bench/hbs_sequencer_bench.sv
/*
 Self-checking bench of the boot-stage sequencer with a flash stand-in.
 Assumes a 40 MHz clock; inputs change at the rising edge, outputs are
 read at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module hbs_sequencer_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_n = 1'b0;
    logic ref_on = 1'b0;
    logic refc = 1'b0;
    logic core_ok = 1'b1;
    logic strap = 1'b0;
    logic dual = 1'b0;
    logic mode3 = 1'b0;
    logic det_en = 1'b0;
    logic [1:0] rsel = 2'h0;
    logic bc_done = 1'b0;
    logic bdone = 1'b0;
    logic [1:0] bres = 2'h0;
    logic hdone = 1'b0;
    logic host_up = 1'b0;
    logic [31:0] sig = 32'h0;
    wire logic io0;
    wire logic io1;
    hbs_pkg::hbs_stage_e stage;
    hbs_pkg::hbs_spi_s spi;
    logic ports_hiz, reg33_en, reg12_en, pll_en, core_reset, load_defaults, speed_fast, smbus_accept;
    logic ring_oscillator_en, cpu_wake, bcd_start, bcd_abort, irq_n, scl_pd_en, sda_pd_en, ext_rom_en;
    logic int_defaults;
    logic [1:0] charger_detect_out;
    logic [15:0] boot_vector;
    logic [2:0] evt;
    logic [31:0] fcmd;
    int miscompares = 0;
    int checks = 0;
    assign evt = {bcd_abort, bcd_start, load_defaults};
    always #12.5 clk = ~clk;
    always @(posedge clk) if (ref_on) refc <= ~refc;
    hbs_sequencer i_hbs_sequencer (
        .clk(clk), .rst_n(rst_n), .chip_reset_pin_n(pin_n), .reference_clock_in(refc),
        .pll_locked_in(ref_on), .core_reg_ok_in(core_ok), .flash_speed_strap(strap),
        .spi_dual_cfg(dual), .spi_mode3_cfg(mode3), .charger_det_en(det_en), .report_sel(rsel),
        .cpu_bc_done(bc_done), .bcd_done(bdone), .bcd_result(bres), .host_cfg_done(hdone),
        .spi_io0_in(io0), .spi_io1_in(io1), .scl_in(host_up), .sda_in(host_up), .stage(stage),
        .ports_hiz(ports_hiz), .reg33_en(reg33_en), .reg12_en(reg12_en), .pll_en(pll_en),
        .core_reset(core_reset), .load_defaults(load_defaults), .speed_fast(speed_fast),
        .smbus_accept(smbus_accept), .ring_oscillator_en(ring_oscillator_en), .cpu_wake(cpu_wake),
        .bcd_start(bcd_start), .bcd_abort(bcd_abort), .irq_n(irq_n),
        .charger_detect_out(charger_detect_out), .spi(spi), .scl_pd_en(scl_pd_en),
        .sda_pd_en(sda_pd_en), .ext_rom_en(ext_rom_en), .boot_vector(boot_vector),
        .int_defaults(int_defaults)
    );
    hbs_flash_model i_hbs_flash_model (
        .sclk(spi.sclk), .cs_n(spi.cs_n), .mosi(spi.io0_o), .dual(dual), .sig(sig), .io0(io0), .io1(io1),
        .cmd(fcmd)
    );
    task results;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_st(input hbs_pkg::hbs_stage_e s);
        int n;
        for (n = 0; n < 3000 && stage !== s; n++) @(negedge clk);
        if (stage !== s) begin
            miscompares++;
            results();
        end
    endtask
    task wait_ev(input int k);
        int n;
        for (n = 0; n < 3000 && evt[k] !== 1'b1; n++) @(negedge clk);
        if (evt[k] !== 1'b1) begin
            miscompares++;
            results();
        end
    endtask
    task pulse_bc;
        @(posedge clk) bc_done <= 1'b1;
        @(posedge clk) bc_done <= 1'b0;
    endtask
    // Standby entry from any stage, then release into hardware init
    task boot(input logic r);
        @(posedge clk) pin_n <= 1'b0;
        ref_on <= r;
        // Long enough for a stopped reference to read as absent
        repeat (50) @(negedge clk);
        chk(stage, hbs_pkg::st_standby);
        chk({ports_hiz, reg33_en, reg12_en, pll_en}, 16'h0008);
        chk(reg33_en, 16'h0000);
        chk(ext_rom_en, 16'h0000);
        @(posedge clk) pin_n <= 1'b1;
        wait_st(hbs_pkg::hardware_init_stage);
        chk({reg33_en, core_reset}, 16'h0003);
        chk(smbus_accept, 16'h0000);
        wait_ev(0);
        chk(speed_fast, strap);
    endtask
    task t_ext_boot;
        strap <= 1'b1;
        sig <= hbs_pkg::FLASH_SIG;
        boot(1'b1);
        chk(stage, hbs_pkg::firmware_init_stage);
        wait_st(hbs_pkg::st_ext_boot);
        chk(ext_rom_en, 16'h0001);
        chk(boot_vector, hbs_pkg::BOOT_ADDR);
        chk(fcmd[31:16], {hbs_pkg::CMD_READ, hbs_pkg::SIG_ADDR[23:16]});
        chk(fcmd[15:0], hbs_pkg::SIG_ADDR[15:0]);
    endtask
    task t_charger_host;
        @(posedge clk);
        strap <= 1'b0;
        det_en <= 1'b1;
        rsel <= hbs_pkg::RPT_IRQ;
        sig <= ~hbs_pkg::FLASH_SIG;
        host_up <= 1'b1;
        boot(1'b0);
        chk(stage, hbs_pkg::charger_init_stage);
        chk({ring_oscillator_en, cpu_wake}, 16'h0003);
        pulse_bc();
        wait_st(hbs_pkg::reference_wait_stage);
        wait_ev(1);
        chk(ring_oscillator_en, 16'h0001);
        @(posedge clk) bdone <= 1'b1;
        bres <= 2'h2;
        @(posedge clk) bdone <= 1'b0;
        repeat (3) @(negedge clk);
        chk({irq_n, charger_detect_out}, 16'h0000);
        @(posedge clk) ref_on <= 1'b1;
        wait_st(hbs_pkg::firmware_init_stage);
        wait_st(hbs_pkg::st_bus_probe);
        chk({scl_pd_en, sda_pd_en, ext_rom_en}, 16'h0006);
        wait_st(hbs_pkg::st_host_cfg);
        chk(smbus_accept, 16'h0001);
        @(posedge clk) hdone <= 1'b1;
        @(posedge clk) hdone <= 1'b0;
        wait_st(hbs_pkg::st_configured);
    endtask
    task t_abort_defaults;
        @(posedge clk);
        mode3 <= 1'b1;
        rsel <= hbs_pkg::RPT_CHG;
        host_up <= 1'b0;
        boot(1'b0);
        pulse_bc();
        wait_ev(1);
        @(posedge clk) ref_on <= 1'b1;
        wait_ev(2);
        chk({irq_n, charger_detect_out}, 16'h0004);
        wait_st(hbs_pkg::firmware_init_stage);
        chk({spi.cs_n, spi.sclk}, 16'h0001);
        wait_st(hbs_pkg::st_defaults);
        chk(int_defaults, 16'h0001);
    endtask
    // Dual-bit signature read in clock mode 3
    task t_dual_boot;
        @(posedge clk);
        dual <= 1'b1;
        strap <= 1'b1;
        sig <= hbs_pkg::FLASH_SIG;
        boot(1'b1);
        wait_st(hbs_pkg::st_ext_boot);
        chk(fcmd[31:24], hbs_pkg::CMD_DREAD);
        chk({ext_rom_en, spi.cs_n, spi.sclk}, 16'h0007);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_ext_boot();
        t_charger_host();
        t_abort_defaults();
        t_dual_boot();
        results();
    end
endmodule
`default_nettype wire
